// [rtl/prog_entry_pkg.sv]
// Constants shared by the programming-mode entry control block
package prog_entry_pkg;
  // Delivered default of the low-voltage enable bit in configuration word one
  localparam logic LV_ENABLE_RESET = 1'h1;
  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
  // Bench figure for the link clock, for reference only
  localparam int LINK_CLK_PERIOD_NS = 160;
  localparam int SYS_CLK_PERIOD_NS = 8;
  // Settle count after master-clear release before entry is judged
  localparam logic [3:0] ENTRY_SETTLE_CYCLES = 4'h3;
endpackage

// [rtl/pin_sync.sv]
// Two flip-flop synchroniser for one asynchronous pin level
`timescale 1ns/1ps
module pin_sync (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_async,
  output logic o_sync
);
  logic meta;

  // First stage is read only by the second stage
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= 1'h0;
      o_sync <= 1'h0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // pin_sync

// [rtl/prog_mode_entry_control.sv]
// Programming-mode entry control and ownership of the programming pins
//
// Overview of operation
// - Two-line serial programming: clock plus bidirectional data
// - Low-voltage enable set reserves mode-select pin
// - Enable cleared releases mode-select pin to I/O
// - Enable bit writable only in high-voltage session
// - Enable cleared: only high-voltage entry allowed
// - High-voltage entry always allowed
// - Enabled: select high enters programming, even floating
// - Enable bit defaults set; clearing disables it
// - Programming pins shared with secondary oscillator pins
`timescale 1ns/1ps
module prog_mode_entry_control (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_master_clear_pin,
  input wire logic i_high_voltage_entry_level,
  input wire logic i_prog_mode_select_pin,
  input wire logic i_serial_prog_clock,
  input wire logic i_serial_prog_data,
  input wire logic i_prog_data_out,
  input wire logic i_prog_data_drive,
  input wire logic i_enable_write_req,
  input wire logic i_enable_write_value,
  input wire logic i_port_b_pin_three_out,
  input wire logic i_port_b_pin_three_oe,
  input wire logic i_secondary_osc_enable,
  output logic o_low_voltage_prog_enable,
  output logic o_prog_mode,
  output logic o_hv_session,
  output logic o_lv_session,
  output logic o_cpu_rstn,
  output logic o_port_b_pin_three_in,
  output logic o_prog_mode_select_oe,
  output logic o_prog_mode_select_out,
  output logic o_serial_prog_clock_rise,
  output logic o_serial_prog_data_in,
  output logic o_serial_prog_data_out,
  output logic o_serial_prog_data_oe,
  output logic o_secondary_osc_active,
  output logic o_enable_write_refused
);
  typedef enum logic [1:0] {RUN_RESET, SETTLE, RUN, PROG} entry_state_e;

  entry_state_e state;
  entry_state_e next_state;
  logic clear_s;
  logic hv_s;
  logic sel_s;
  logic pclk_s;
  logic pdata_s;
  logic pclk_d;
  logic [3:0] settle_cnt;
  logic lv_enable;
  logic hv_sess;
  logic lv_sess;

  // Every pin from the far side passes two flops before logic sees it
  pin_sync u_sync_clear (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(i_master_clear_pin),
    .o_sync(clear_s)
  );
  pin_sync u_sync_hv (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(i_high_voltage_entry_level),
    .o_sync(hv_s)
  );
  pin_sync u_sync_sel (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(i_prog_mode_select_pin),
    .o_sync(sel_s)
  );
  // Link clock is sampled like any pin; its edges are found after the second flop
  pin_sync u_sync_pclk (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(i_serial_prog_clock),
    .o_sync(pclk_s)
  );
  pin_sync u_sync_pdata (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(i_serial_prog_data),
    .o_sync(pdata_s)
  );

  // Entry decode: high voltage always wins, low voltage only while enabled
  wire hv_entry = hv_s;
  wire lv_entry = lv_enable && sel_s;
  wire entry_ok = hv_entry || lv_entry;
  wire settle_done = (settle_cnt == prog_entry_pkg::ENTRY_SETTLE_CYCLES);
  wire pclk_rise = pclk_s && !pclk_d;
  // Enable bit may only change inside a session entered by high voltage
  wire enable_write_ok = i_enable_write_req && (state == PROG) && hv_sess;
  wire enable_refused = i_enable_write_req && !enable_write_ok;
  wire in_prog = (state == PROG);
  // Pins are shared with the oscillator; programming takes them over
  wire osc_active = i_secondary_osc_enable && !in_prog;

  // Entry sequencing: judged after master-clear release, left on its fall
  always_comb begin
    next_state = state;
    unique case (state)
      RUN_RESET: if (clear_s) next_state = SETTLE;
      SETTLE: begin
        if (!clear_s) next_state = RUN_RESET;
        else if (settle_done) next_state = entry_ok ? PROG : RUN;
      end
      RUN: if (!clear_s) next_state = RUN_RESET;
      PROG: if (!clear_s) next_state = RUN_RESET;
    endcase
  end

  // State and settle counter; the counter rides out pin skew at release
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= RUN_RESET;
      settle_cnt <= 4'h0;
    end else begin
      state <= next_state;
      settle_cnt <= (state == SETTLE) ? settle_cnt + 4'h1 : 4'h0;
    end
  end

  // Session type latched at entry so a mid-session drop of high voltage
  // does not change what the session may do
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      hv_sess <= 1'b0;
      lv_sess <= 1'b0;
    end else if (state == SETTLE && settle_done && clear_s) begin
      hv_sess <= hv_entry;
      lv_sess <= !hv_entry && lv_entry;
    end else if (next_state != PROG) begin
      hv_sess <= 1'b0;
      lv_sess <= 1'b0;
    end
  end

  // Low-voltage enable bit, delivered set
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lv_enable <= prog_entry_pkg::LV_ENABLE_RESET;
    end else if (enable_write_ok) begin
      lv_enable <= i_enable_write_value;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pclk_d <= 1'h0;
      o_low_voltage_prog_enable <= prog_entry_pkg::LV_ENABLE_RESET;
      o_prog_mode <= 1'h0;
      o_hv_session <= 1'h0;
      o_lv_session <= 1'h0;
      o_cpu_rstn <= 1'h0;
      o_port_b_pin_three_in <= 1'h0;
      o_prog_mode_select_oe <= 1'h0;
      o_prog_mode_select_out <= 1'h0;
      o_serial_prog_clock_rise <= 1'h0;
      o_serial_prog_data_in <= 1'h0;
      o_serial_prog_data_out <= 1'h0;
      o_serial_prog_data_oe <= 1'h0;
      o_secondary_osc_active <= 1'h0;
      o_enable_write_refused <= 1'h0;
    end else begin
      pclk_d <= pclk_s;
      o_low_voltage_prog_enable <= lv_enable;
      o_prog_mode <= in_prog;
      o_hv_session <= hv_sess;
      o_lv_session <= lv_sess;
      // Core runs only in normal operation, held through settle and programming
      o_cpu_rstn <= (state == RUN);
      // Mode-select pin is general I/O only while the enable bit is clear
      o_port_b_pin_three_in <= lv_enable ? 1'h0 : sel_s;
      o_prog_mode_select_oe <= lv_enable ? 1'h0 : i_port_b_pin_three_oe;
      o_prog_mode_select_out <= lv_enable ? 1'h0 : i_port_b_pin_three_out;
      // Serial link: clock edge found by sampling, data is two-way
      o_serial_prog_clock_rise <= in_prog && pclk_rise;
      o_serial_prog_data_in <= pdata_s;
      o_serial_prog_data_out <= in_prog ? i_prog_data_out : 1'h0;
      o_serial_prog_data_oe <= in_prog && i_prog_data_drive;
      o_secondary_osc_active <= osc_active;
      o_enable_write_refused <= enable_refused;
    end
  end

  // Assertions
  a_pin_reserved: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    lv_enable |=> !o_prog_mode_select_oe && !o_port_b_pin_three_in)
    else $error("mode-select pin used as I/O while low-voltage enabled");
  a_pin_release: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !lv_enable |=> o_prog_mode_select_oe == $past(i_port_b_pin_three_oe))
    else $error("mode-select pin not released to I/O");
  a_enable_write_guard: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (lv_enable != $past(lv_enable)) |-> $past(state == PROG && hv_sess && i_enable_write_req))
    else $error("enable bit changed outside a high-voltage session");
  // A refused write must be reported, so software can tell it did not land
  a_write_refusal: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_enable_write_req && !(in_prog && hv_sess)) |=> o_enable_write_refused)
    else $error("refused enable write not reported");
  a_lv_entry_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (state == SETTLE && settle_done && clear_s && !lv_enable && !hv_s) |=> state == RUN)
    else $error("entry without high voltage while enable clear");
  a_hv_entry_always: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (state == SETTLE && settle_done && clear_s && hv_s) |=> state == PROG ##1 o_hv_session)
    else $error("high-voltage entry refused");
  a_lv_entry_taken: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (state == SETTLE && settle_done && clear_s && lv_enable && sel_s) |=> in_prog)
    else $error("low-voltage entry missed with select high");
  a_session_exclusive: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !(o_hv_session && o_lv_session))
    else $error("both session kinds flagged at once");
  a_exit_on_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (in_prog && !clear_s) |=> state == RUN_RESET ##1 !o_prog_mode && !o_cpu_rstn)
    else $error("programming not left on master-clear low");
  a_core_held_prog: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_prog_mode |-> !o_cpu_rstn)
    else $error("core released while programming");
  a_clock_rise_prog: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_serial_prog_clock_rise |-> o_prog_mode)
    else $error("link clock edge passed on outside programming");
  a_data_drive_prog: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_serial_prog_data_oe |-> $past(in_prog))
    else $error("data pin driven outside programming");
  a_osc_yields: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_prog_mode |-> !o_secondary_osc_active)
    else $error("oscillator active during programming");
endmodule // prog_mode_entry_control

// [sim/prog_tool_model.sv]
// Programmer model driving the entry pins and the link clock
`timescale 1ns/1ps
module prog_tool_model (
  input wire logic i_clk_sys,
  output logic o_master_clear_pin,
  output logic o_high_voltage_entry_level,
  output logic o_prog_mode_select_pin,
  output logic o_serial_prog_clock
);
  // Pull-down keeps select low so the part boots normally
  initial begin
    o_master_clear_pin = 1'h0;
    o_high_voltage_entry_level = 1'h0;
    o_prog_mode_select_pin = 1'h0;
    o_serial_prog_clock = 1'h0;
  end
  // Clear low, levels set, clear high at supply or high level
  task automatic enter(input logic hv, input logic sel);
    @(negedge i_clk_sys);
    o_master_clear_pin = 1'h0;
    repeat (4) @(negedge i_clk_sys);
    o_high_voltage_entry_level = hv;
    o_prog_mode_select_pin = sel;
    repeat (4) @(negedge i_clk_sys);
    o_master_clear_pin = 1'h1;
    repeat (16) @(negedge i_clk_sys);
  endtask
  // Levels held until clear low has been seen inside
  task automatic leave();
    o_master_clear_pin = 1'h0;
    repeat (8) @(negedge i_clk_sys);
    o_high_voltage_entry_level = 1'h0;
    o_prog_mode_select_pin = 1'h0;
    repeat (4) @(negedge i_clk_sys);
  endtask
  // Link clock only runs inside a session and idles low between frames
  task automatic clocks(input int n);
    repeat (n) begin
      #80 o_serial_prog_clock = 1'h1;
      #80 o_serial_prog_clock = 1'h0;
    end
  endtask
endmodule // prog_tool_model

// [sim/prog_mode_entry_control_tb_top.sv]
// Self-checking bench for programming-mode entry control
`timescale 1ns/1ps
module prog_mode_entry_control_tb_top;
  logic i_clk_sys = 1'h0;
  logic i_rstn = 1'h0;
  logic i_master_clear_pin, i_high_voltage_entry_level, i_prog_mode_select_pin, i_serial_prog_clock;
  logic i_prog_data_out = 1'h0, i_prog_data_drive = 1'h0, i_enable_write_req = 1'h0, i_enable_write_value = 1'h0;
  // Software has cleared the direction bit, so the pin drives and no pull-up lifts it
  logic i_port_b_pin_three_out = 1'h1, i_port_b_pin_three_oe = 1'h1;
  logic i_secondary_osc_enable = 1'h1;
  logic o_low_voltage_prog_enable, o_prog_mode, o_hv_session, o_lv_session, o_cpu_rstn;
  logic o_port_b_pin_three_in, o_prog_mode_select_oe, o_prog_mode_select_out, o_serial_prog_clock_rise;
  logic o_serial_prog_data_in, o_serial_prog_data_out, o_serial_prog_data_oe, o_secondary_osc_active;
  logic o_enable_write_refused;
  wire logic i_serial_prog_data;
  int error_cnt = 0, compares = 0, cycles = 0, rises = 0, refusals = 0;
  // Rows: hv, select, then expected prog, hv session, lv session
  logic [4:0] rows [4] = '{5'h00, 5'h0D, 5'h16, 5'h1E};
  // Tool idles the data line high; the device wins while driving
  assign i_serial_prog_data = o_serial_prog_data_oe ? o_serial_prog_data_out : 1'h1;
  prog_mode_entry_control u_prog_mode_entry_control (.i_clk_sys, .i_rstn, .i_master_clear_pin,
    .i_high_voltage_entry_level, .i_prog_mode_select_pin, .i_serial_prog_clock, .i_serial_prog_data,
    .i_prog_data_out, .i_prog_data_drive, .i_enable_write_req, .i_enable_write_value, .i_port_b_pin_three_out,
    .i_port_b_pin_three_oe, .i_secondary_osc_enable, .o_low_voltage_prog_enable, .o_prog_mode,
    .o_hv_session, .o_lv_session, .o_cpu_rstn, .o_port_b_pin_three_in, .o_prog_mode_select_oe,
    .o_prog_mode_select_out, .o_serial_prog_clock_rise, .o_serial_prog_data_in, .o_serial_prog_data_out,
    .o_serial_prog_data_oe, .o_secondary_osc_active, .o_enable_write_refused);
  prog_tool_model u_prog_tool_model (.i_clk_sys(i_clk_sys), .o_master_clear_pin(i_master_clear_pin),
    .o_high_voltage_entry_level(i_high_voltage_entry_level),
    .o_prog_mode_select_pin(i_prog_mode_select_pin), .o_serial_prog_clock(i_serial_prog_clock));
  initial begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Write pulse for the enable bit, then let it land
  task automatic write_enable(input logic v);
    @(negedge i_clk_sys);
    i_enable_write_req = 1'h1;
    i_enable_write_value = v;
    @(negedge i_clk_sys);
    i_enable_write_req = 1'h0;
    repeat (4) @(negedge i_clk_sys);
  endtask
  // Pulse counters and the hang limit
  always @(posedge i_clk_sys) begin
    rises += (o_serial_prog_clock_rise === 1'h1);
    refusals += (o_enable_write_refused === 1'h1);
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(negedge i_clk_sys);
    i_rstn = 1'h1;
    check({2'h0, o_low_voltage_prog_enable}, 3'h1);
    foreach (rows[k]) begin
      u_prog_tool_model.enter(rows[k][4], rows[k][3]);
      check({o_prog_mode, o_hv_session, o_lv_session}, rows[k][2:0]);
      check({o_cpu_rstn, o_prog_mode_select_oe, o_port_b_pin_three_in}, {~rows[k][2], 2'h0});
      u_prog_tool_model.leave();
      // Master-clear still low after leaving: core stays held in reset
      check({1'h0, o_prog_mode, o_cpu_rstn}, 3'h0);
      $display("table row %0d done", k);
    end
    // Low-voltage session: write refused, link clock and data line work
    u_prog_tool_model.enter(1'h0, 1'h1);
    write_enable(1'h0);
    check({o_low_voltage_prog_enable, refusals[1:0]}, 3'h5);
    u_prog_tool_model.clocks(4);
    i_prog_data_drive = 1'h1;
    repeat (6) @(negedge i_clk_sys);
    check(rises[2:0], 3'h4);
    check({o_serial_prog_data_oe, o_serial_prog_data_in, o_secondary_osc_active}, 3'h4);
    u_prog_tool_model.leave();
    check({1'h0, o_serial_prog_data_oe, o_secondary_osc_active}, 3'h1);
    $display("low-voltage session test done");
    // High-voltage session clears the enable and frees the pin
    u_prog_tool_model.enter(1'h1, 1'h0);
    write_enable(1'h0);
    u_prog_tool_model.leave();
    check({o_low_voltage_prog_enable, refusals[1:0]}, 3'h1);
    check({1'h0, o_prog_mode_select_oe, o_prog_mode_select_out}, 3'h3);
    u_prog_tool_model.enter(1'h0, 1'h1);
    check({2'h0, o_prog_mode}, 3'h0);
    u_prog_tool_model.leave();
    u_prog_tool_model.enter(1'h1, 1'h1);
    check({1'h0, o_prog_mode, o_hv_session}, 3'h3);
    u_prog_tool_model.leave();
    $display("high-voltage session test done");
    // Second reset restores the delivered default
    i_rstn = 1'h0;
    repeat (2) @(negedge i_clk_sys);
    i_rstn = 1'h1;
    check({o_prog_mode, o_cpu_rstn, o_low_voltage_prog_enable}, 3'h1);
    $display("reset test done");
    final_report();
  end
endmodule // prog_mode_entry_control_tb_top
